// ### design/swc_regs.svh
// Register offsets, field positions and reset values of the single-wire port
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH

`define OFS_BAUD_LO 16'he20c
`define OFS_BAUD_HI 16'he20d
`define OFS_SYSCTL 16'he20e
`define OFS_STATE 16'he20f
`define OFS_FORMAT 16'he210

`define DIV_RST 16'hffff
`define DIV_LO_RST 8'hff
`define DIV_DEBUG_MAX 16'h0030
`define MODE_RST 1'b1
`define FMT_RST 8'h00
`define DEBUG_FMT 8'h03

`define SYS_MODE 7
`define SYS_PERR 6
`define SYS_FERR 5
`define SYS_RST_MODE 1
`define SYS_RST_ROOT 0

`define FMT_LEN 1:0
`define FMT_STOP 2
`define FMT_PAR 5:3
`define FMT_PAR_EN 3
`define FMT_PAR_KIND 5:4
`define FMT_MASK 6
`define LEN_BASE 4'h5
`define PAR_HIGH 3'h5

`define AB_LAST_FALL 3'h3
`define AB_SHIFT 3

`endif

// ### design/swc_pkg.sv
// Types shared by the single-wire port design
`default_nettype none

package swc_pkg;

    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_START = 5'h02,
        RX_DATA = 5'h04,
        RX_PAR = 5'h08,
        RX_STOP = 5'h10
    } rx_state_t;

    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_START = 5'h02,
        TX_DATA = 5'h04,
        TX_PAR = 5'h08,
        TX_STOP = 5'h10
    } tx_state_t;

endpackage

`default_nettype wire

// ### design/single_wire_comm_port.sv
// Single-wire serial port with auto-baud, mode control and debug flags
// Overview of operation
// - Bit rate is clock over the 16-bit divisor; rewritable any time.
// - Control bit 7 forces debug (0 to 1) or UART (1 to 0) mode.
// - Debug parity and framing flags set on errors, cleared by writing one.
// - Control bit 1 resets current mode's internal state; mode still loads from bit 7.
// - Control bit 0 returns port to awaiting divisor or 0x55 character.
// - Internal resets leave transmit and receive FIFO contents intact.
// - State register gives 16 bits: low byte first read, high second.
// - Characters carry 5 to 8 data bits, LSB first, after low start bit.
// - Odd or even parity makes ones count over data and parity odd/even.
// - Sticky parity sends fixed 1 or 0; receiver checks that value.
// - Parity disabled: no parity bit sent, none checked, no error.
// - One or two stop bits sent; receiver checks only the first.
// - Start edge sampled half a bit later; high sample returns idle.
// - Data bits sampled at centres, first one bit after start centre.
// - Parity bit sampled at centre; mismatch raises parity error.
// - First stop bit sampled; low raises framing error; back to idle.
// - Received line passes a majority-vote noise filter.
// - Mask bit decides whether own transmitted characters are received.
// - After reset, time a 0x55 8N1 character and load the divisor.
// - Parity codes: 001 odd, 011 even, 101 high, 111 low, else none.
// - Length 00..11 means 5..8 bits; stop 0 one bit, 1 two.
// - Divisor load reinitialises; above 48 UART mode, else debug mode.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "swc_regs.svh"

module single_wire_comm_port
    import swc_pkg::*;
(
    input wire logic core_clk, // 20 MHz oscillator clock
    input wire logic rst_n, // Synchronous reset
    input wire logic [15:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic line_in, // Wire level from pin
    output logic line_out, // Level driven onto wire
    output logic line_oe, // High while driving wire
    input wire logic [7:0] tx_data, // Character to send
    input wire logic tx_valid, // Character offered
    output logic tx_ready, // Transmitter takes character
    output logic [7:0] rx_data, // Received character
    output logic rx_valid, // Received character pulse
    output logic rx_parity_err, // UART parity error pulse
    output logic rx_framing_err // UART framing error pulse
);

    // ==========================================================
    // Register decode
    logic wr_lo, wr_hi, wr_sys, wr_fmt, rd_state;
    logic [7:0] div_lo, fmt;
    logic [15:0] divisor, div_sel, ab_div, state_word;
    logic mode, perr, ferr, awaiting, state_hi, reinit, ab_done;
    rx_state_t rx_state;
    tx_state_t tx_state;

    assign wr_lo = reg_wr && (reg_addr == `OFS_BAUD_LO);
    assign wr_hi = reg_wr && (reg_addr == `OFS_BAUD_HI);
    assign wr_sys = reg_wr && (reg_addr == `OFS_SYSCTL);
    assign wr_fmt = reg_wr && (reg_addr == `OFS_FORMAT);
    assign rd_state = reg_rd && (reg_addr == `OFS_STATE);
    assign div_sel = wr_hi ? {reg_wdata, div_lo} : ab_div;

    // internal reinit
    // Reinit never reaches the FIFOs, which sit outside this block
    // FIFOs untouched
    assign reinit = wr_hi || ab_done || (wr_sys &&
        (reg_wdata[`SYS_RST_MODE] || reg_wdata[`SYS_RST_ROOT]));

    // ==========================================================
    // Divisor and mode
    // low byte staged
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_lo <= `DIV_LO_RST;
        end else if (wr_lo) begin
            div_lo <= reg_wdata;
        end else if (ab_done) begin
            div_lo <= ab_div[7:0];
        end
    end

    // divisor commit
    // Taking effect on the high byte keeps the rate from glitching
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            divisor <= `DIV_RST;
        end else if (wr_hi || ab_done) begin
            divisor <= div_sel;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode <= `MODE_RST;
        end else if (wr_hi || ab_done) begin
            mode <= (div_sel <= `DIV_DEBUG_MAX);
        end else if (wr_sys) begin
            mode <= reg_wdata[`SYS_MODE];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            awaiting <= 1'b1;
        end else if (wr_sys && reg_wdata[`SYS_RST_ROOT]) begin
            awaiting <= 1'b1;
        end else if (wr_hi || ab_done) begin
            awaiting <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fmt <= `FMT_RST;
        end else if (wr_fmt) begin
            fmt <= reg_wdata;
        end
    end

    // ==========================================================
    // Character format
    logic [7:0] eff_fmt, len_mask;
    logic [3:0] nbits;
    logic par_on;
    logic [15:0] half;

    // Debug traffic is always eight bits, no parity, one stop
    assign eff_fmt = mode ? `DEBUG_FMT : fmt;
    assign nbits = {2'b00, eff_fmt[`FMT_LEN]} + `LEN_BASE;
    assign len_mask = 8'hff >> (2'd3 - eff_fmt[`FMT_LEN]);
    assign par_on = eff_fmt[`FMT_PAR_EN];
    // divisor above three keeps half at least two
    assign half = {1'b0, divisor[15:1]};

    function automatic logic par_bit(input logic [1:0] kind, input logic ones);
        case (kind)
            2'b00: par_bit = ~ones;
            2'b01: par_bit = ones;
            2'b10: par_bit = 1'b1;
            default: par_bit = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // Input synchroniser and noise filter
    logic sync1, sync2, rx_line, rx_prev, rx_fall;
    logic [2:0] samp;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
        end else begin
            sync1 <= line_in;
            sync2 <= sync1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            samp <= 3'h7;
            rx_line <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            samp <= {samp[1:0], sync2};
            rx_line <= (samp[0] & samp[1]) | (samp[1] & samp[2]) |
                (samp[0] & samp[2]);
            rx_prev <= rx_line;
        end
    end

    assign rx_fall = rx_prev && !rx_line;

    // ==========================================================
    // Auto-baud measurement
    logic ab_run;
    logic [2:0] ab_falls;
    logic [18:0] ab_cnt, ab_sum;

    // first to fifth falling edge of 0x55 spans eight bits
    assign ab_done = awaiting && ab_run && rx_fall &&
        (ab_falls == `AB_LAST_FALL);
    assign ab_sum = ab_cnt + 19'h00001;
    assign ab_div = ab_sum[18:`AB_SHIFT];

    always_ff @(posedge core_clk) begin
        if (!rst_n || !awaiting || ab_done) begin
            ab_run <= 1'b0;
            ab_falls <= 3'h0;
            ab_cnt <= 19'h00000;
        end else if (!ab_run) begin
            ab_run <= rx_fall;
            ab_cnt <= 19'h00000;
        end else begin
            ab_cnt <= ab_cnt + 19'h00001;
            if (rx_fall) begin
                ab_falls <= ab_falls + 3'h1;
            end
        end
    end

    // ==========================================================
    // Transmitter
    logic [15:0] tx_cnt;
    logic [7:0] tx_sh;
    logic [3:0] tx_idx;
    logic tx_tick, tx_par, tx_more;

    assign tx_tick = (tx_cnt == divisor - 16'h0001);
    assign tx_ready = (tx_state == TX_IDLE) && !awaiting;

    always_ff @(posedge core_clk) begin
        if (!rst_n || reinit || tx_state == TX_IDLE || tx_tick) begin
            tx_cnt <= 16'h0000;
        end else begin
            tx_cnt <= tx_cnt + 16'h0001;
        end
    end

    // Format is read live; changing it mid-character garbles that character
    always_ff @(posedge core_clk) begin
        if (!rst_n || reinit) begin
            tx_state <= TX_IDLE;
            tx_sh <= 8'h00;
            tx_idx <= 4'h0;
            tx_par <= 1'b0;
            tx_more <= 1'b0;
            line_out <= 1'b1;
            line_oe <= 1'b0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (tx_valid && tx_ready) begin
                        tx_sh <= tx_data;
                        tx_par <= par_bit(eff_fmt[`FMT_PAR_KIND],
                            ^(tx_data & len_mask));
                        line_out <= 1'b0;
                        line_oe <= 1'b1;
                        tx_state <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_tick) begin
                        line_out <= tx_sh[0];
                        tx_sh <= tx_sh >> 1;
                        tx_idx <= 4'h1;
                        tx_state <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_tick) begin
                        if (tx_idx == nbits) begin
                            line_out <= par_on ? tx_par : 1'b1;
                            tx_more <= eff_fmt[`FMT_STOP];
                            tx_state <= par_on ? TX_PAR : TX_STOP;
                        end else begin
                            line_out <= tx_sh[0];
                            tx_sh <= tx_sh >> 1;
                            tx_idx <= tx_idx + 4'h1;
                        end
                    end
                end
                TX_PAR: begin
                    if (tx_tick) begin
                        line_out <= 1'b1;
                        tx_state <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_tick) begin
                        if (tx_more) begin
                            tx_more <= 1'b0;
                        end else begin
                            line_oe <= 1'b0;
                            tx_state <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                    line_oe <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Receiver
    logic [15:0] rx_cnt, rx_target;
    logic [7:0] rx_sh;
    logic [3:0] rx_idx;
    logic rx_tick, rx_pbit, rx_block, rx_done, rx_pe, rx_fe;

    assign rx_block = fmt[`FMT_MASK] && (tx_state != TX_IDLE);
    // half bit to centre, then whole bits
    assign rx_target = (rx_state == RX_START) ? half : divisor;
    assign rx_tick = (rx_cnt == rx_target - 16'h0001);
    assign rx_done = (rx_state == RX_STOP) && rx_tick;
    assign rx_pe = par_on &&
        (rx_pbit != par_bit(eff_fmt[`FMT_PAR_KIND], ^rx_sh));
    assign rx_fe = !rx_line;

    always_ff @(posedge core_clk) begin
        if (!rst_n || rx_state == RX_IDLE || rx_tick) begin
            rx_cnt <= 16'h0000;
        end else begin
            rx_cnt <= rx_cnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || reinit || awaiting || rx_block) begin
            rx_state <= RX_IDLE;
            rx_sh <= 8'h00;
            rx_idx <= 4'h0;
            rx_pbit <= 1'b0;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    if (rx_fall) begin
                        rx_sh <= 8'h00;
                        rx_idx <= 4'h0;
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        rx_state <= rx_line ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rx_sh[rx_idx[2:0]] <= rx_line;
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx == nbits - 4'h1) begin
                            rx_state <= par_on ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_tick) begin
                        rx_pbit <= rx_line;
                        rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_tick) begin
                        rx_state <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_parity_err <= 1'b0;
            rx_framing_err <= 1'b0;
        end else begin
            rx_valid <= rx_done;
            rx_parity_err <= rx_done && rx_pe && !mode;
            rx_framing_err <= rx_done && rx_fe && !mode;
            if (rx_done) begin
                rx_data <= rx_sh;
            end
        end
    end

    // ==========================================================
    // Debug error flags
    // sticky flags, set beats clear
    // Parity is off in debug mode, so the parity flag stays clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            perr <= 1'b0;
            ferr <= 1'b0;
        end else begin
            if (rx_done && mode && rx_pe) begin
                perr <= 1'b1;
            end else if (wr_sys && reg_wdata[`SYS_PERR]) begin
                perr <= 1'b0;
            end
            if (rx_done && mode && rx_fe) begin
                ferr <= 1'b1;
            end else if (wr_sys && reg_wdata[`SYS_FERR]) begin
                ferr <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Register read
    assign state_word = {awaiting, mode, ab_run, ab_falls, rx_state[4:0],
        tx_state[4:0]};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_hi <= 1'b0;
        end else if (rd_state) begin
            state_hi <= !state_hi;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || !reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                `OFS_BAUD_LO: reg_rdata <= div_lo;
                `OFS_BAUD_HI: reg_rdata <= divisor[15:8];
                `OFS_SYSCTL: reg_rdata <= {mode, perr, ferr, 5'h00};
                `OFS_STATE: reg_rdata <= state_hi ? state_word[15:8] :
                    state_word[7:0];
                `OFS_FORMAT: reg_rdata <= fmt;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence tx_take;
        tx_valid && tx_ready && !reinit;
    endsequence

    sequence start_low;
        !line_out && line_oe;
    endsequence

    sequence start_high;
        rx_state == RX_START && rx_tick && rx_line;
    endsequence

    baud_commit_a: assert property (wr_hi |=>
        divisor == {$past(reg_wdata), $past(div_lo)})
        else $error("divisor not loaded from both bytes");
    mode_by_div_a: assert property (wr_hi |=>
        mode == (divisor <= `DIV_DEBUG_MAX) && !awaiting)
        else $error("mode does not follow divisor");
    mode_force_a: assert property (wr_sys && !ab_done |=>
        mode == $past(reg_wdata[`SYS_MODE]))
        else $error("forced mode not taken");
    root_reset_a: assert property (
        wr_sys && reg_wdata[`SYS_RST_ROOT] |=>
        awaiting && rx_state == RX_IDLE && tx_state == TX_IDLE)
        else $error("root reset did not reinitialise");
    debug_perr_a: assert property (!$rose(perr))
        else $error("debug parity flag set");
    start_reject_a: assert property (start_high |=>
        rx_state == RX_IDLE)
        else $error("high start sample accepted");
    tx_start_a: assert property (tx_take |=> start_low)
        else $error("start bit not driven low");
    filter_vote_a: assert property (sync2 [*3] |=> ##1 rx_line)
        else $error("filter did not pass steady high");
    rx_mask_a: assert property (
        fmt[`FMT_MASK] && tx_state != TX_IDLE |=> rx_state == RX_IDLE)
        else $error("own character received while masked");
    par_fixed_a: assert property (
        tx_state == TX_PAR && !mode && fmt[`FMT_PAR] == `PAR_HIGH |->
        line_out)
        else $error("sticky high parity not one");

endmodule

`default_nettype wire

// ### verif/uart_peer.sv
// Behavioural peer that drives and samples characters on the single wire
`timescale 1ns/10ps
`default_nettype none

module uart_peer (
    input wire logic clk, // Bench clock
    input wire logic wire_lvl, // Resolved wire level
    output logic drv_oe, // High while peer drives
    output logic drv_val // Level driven by peer
);
    initial begin
        drv_oe = 1'b0;
        drv_val = 1'b1;
    end

    task automatic send(input logic [7:0] d, input int n, input int bt, input logic pe,
                        input logic pb, input logic sb);
        drv_oe <= 1'b1;
        drv_val <= 1'b0;
        repeat (bt) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            drv_val <= d[i];
            repeat (bt) @(posedge clk);
        end
        if (pe) begin
            drv_val <= pb;
            repeat (bt) @(posedge clk);
        end
        drv_val <= sb;
        repeat (bt) @(posedge clk);
        // Released wire rises through the pull-up
        drv_oe <= 1'b0;
        drv_val <= 1'b1;
        repeat (bt) @(posedge clk);
    endtask

    task automatic glitch(input int n);
        drv_oe <= 1'b1;
        drv_val <= 1'b0;
        repeat (n) @(posedge clk);
        drv_oe <= 1'b0;
        drv_val <= 1'b1;
    endtask

    task automatic recv(input int n, input int bt, input logic pe, output logic [7:0] d,
                        output logic pb, output logic sb);
        int k;
        k = 0;
        d = 8'h00;
        pb = 1'b0;
        while (wire_lvl !== 1'b0 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        repeat (bt / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            repeat (bt) @(posedge clk);
            d[i] = wire_lvl;
        end
        if (pe) begin
            repeat (bt) @(posedge clk);
            pb = wire_lvl;
        end
        repeat (bt) @(posedge clk);
        sb = wire_lvl;
    endtask
endmodule

`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the single-wire port
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam int BT = 60;
    localparam int DBG = 48;
    logic core_clk, rst_n, reg_wr, reg_rd, tx_valid, line_out, line_oe, tx_ready;
    logic rx_valid, rx_parity_err, rx_framing_err, peer_oe, peer_val, wire_lvl;
    logic last_perr, last_ferr;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, tx_data, rx_data, last_rx;
    int mismatches, total_checks, rx_count;

    // Pull-up holds the wire high when nobody drives
    assign wire_lvl = line_oe ? line_out : (peer_oe ? peer_val : 1'b1);

    single_wire_comm_port i_single_wire_comm_port (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .line_in(wire_lvl), .line_out(line_out), .line_oe(line_oe),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err));
    uart_peer i_uart_peer (.clk(core_clk), .wire_lvl(wire_lvl), .drv_oe(peer_oe),
        .drv_val(peer_val));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (rx_valid === 1'b1) begin
            rx_count <= rx_count + 1;
            last_rx <= rx_data;
            last_perr <= rx_parity_err;
            last_ferr <= rx_framing_err;
        end
    end

    // ==========
    // Shared tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string what);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        // Read data stands only in the cycle after the strobe
        @(negedge core_clk);
        check(what, 16'(reg_rdata), 16'(exp));
        @(posedge core_clk);
    endtask

    function automatic logic par_bit(input logic [2:0] code, input logic [7:0] d);
        case (code)
            3'b001: return ~^d;
            3'b011: return ^d;
            3'b101: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    task automatic rx_one(input logic [7:0] fmt, input logic [7:0] d, input logic pb,
                          input logic sb, input logic ep, input logic ef);
        int c;
        c = rx_count;
        wr(16'he210, fmt);
        i_uart_peer.send(d, 5 + fmt[1:0], BT, fmt[3], pb, sb);
        check("rx count", 16'(rx_count - c), 16'h1);
        check("rx data", 16'(last_rx), 16'(d));
        check("parity err", 16'(last_perr), 16'(ep));
        check("framing err", 16'(last_ferr), 16'(ef));
    endtask

    task automatic tx_one(input logic [7:0] fmt, input logic [7:0] d);
        int c;
        logic [7:0] got;
        logic gp, gs;
        wr(16'he210, fmt);
        c = rx_count;
        check("tx ready", 16'(tx_ready), 16'h1);
        tx_data <= d;
        tx_valid <= 1'b1;
        fork
            begin
                @(posedge core_clk);
                tx_valid <= 1'b0;
            end
            i_uart_peer.recv(5 + fmt[1:0], BT, fmt[3], got, gp, gs);
        join
        check("tx data", 16'(got), 16'(d));
        if (fmt[3]) check("tx parity", 16'(gp), 16'(par_bit(fmt[5:3], d)));
        check("tx stop", 16'(gs), 16'h1);
        repeat (BT) @(posedge core_clk);
        check("second stop", 16'(line_oe), 16'(fmt[2]));
        repeat (BT) @(posedge core_clk);
        check("own echo", 16'(rx_count - c), 16'(!fmt[6]));
    endtask

    // ==========
    // Scenarios
    task automatic t_autobaud();
        i_uart_peer.send(8'h55, 8, BT, 1'b0, 1'b0, 1'b1);
        check("ready", 16'(tx_ready), 16'h1);
        rdchk(16'he20c, 8'(BT), "baud low");
        rdchk(16'he20d, 8'h00, "baud high");
        rdchk(16'he20e, 8'h00, "uart mode");
        rdchk(16'he211, 8'h00, "unmapped");
    endtask

    task automatic t_rx();
        logic [2:0] code;
        int c;
        rx_one(8'h03, 8'ha5, 1'b0, 1'b1, 1'b0, 1'b0);
        rx_one(8'h00, 8'h16, 1'b0, 1'b1, 1'b0, 1'b0);
        rx_one(8'h07, 8'h3c, 1'b0, 1'b1, 1'b0, 1'b0);
        rx_one(8'h13, 8'h3c, 1'b0, 1'b1, 1'b0, 1'b0);
        rx_one(8'h03, 8'h3c, 1'b0, 1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 8; i++) begin
            code = 3'(2 * (i / 2) + 1);
            rx_one({2'b00, code, 3'b011}, 8'h35, par_bit(code, 8'h35) ^ i[0], 1'b1, i[0],
                   1'b0);
        end
        c = rx_count;
        i_uart_peer.glitch(1);
        repeat (BT) @(posedge core_clk);
        i_uart_peer.glitch(10);
        repeat (2 * BT) @(posedge core_clk);
        check("noise", 16'(rx_count - c), 16'h0);
    endtask

    task automatic t_tx();
        logic [7:0] fmts [5] = '{8'h4b, 8'h5f, 8'h6b, 8'h7b, 8'h00};
        for (int i = 0; i < 5; i++) begin
            tx_one(fmts[i], (i == 4) ? 8'h16 : 8'h35);
        end
    endtask

    task automatic t_debug();
        // divisor above three, low byte first
        wr(16'he20c, 8'(DBG));
        wr(16'he20d, 8'h00);
        rdchk(16'he20e, 8'h80, "debug mode");
        i_uart_peer.send(8'h00, 8, DBG, 1'b0, 1'b0, 1'b0);
        rdchk(16'he20e, 8'ha0, "debug flags");
        // control register written only in this scenario
        wr(16'he20e, 8'ha0);
        rdchk(16'he20e, 8'h80, "flag clear");
        wr(16'he20e, 8'h00);
        rdchk(16'he20e, 8'h00, "forced uart");
        wr(16'he20e, 8'h02);
        rdchk(16'he20e, 8'h00, "mode kept");
        rdchk(16'he20f, 8'h21, "state low");
        rdchk(16'he20f, 8'h00, "state high");
        wr(16'he20e, 8'h01);
        check("awaiting", 16'(tx_ready), 16'h0);
    endtask

    // ==========
    // Run control
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        give_verdict();
    end

    initial begin
        mismatches = 0;
        total_checks = 0;
        rx_count = 0;
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_autobaud();
        t_rx();
        t_tx();
        t_debug();
        give_verdict();
    end
endmodule

`default_nettype wire
